//--- logic/qds_host.sv
// Serial load controller: AHB-Lite registers in, framed serial words out
//
// The register offsets and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module qds_host #(
    parameter int unsigned CODE_W = qds_pkg::CODE_W_WIDE,
    parameter int unsigned SCLK_HALF = qds_pkg::SCLK_HALF_DEF,
    parameter int unsigned CS_GAP = qds_pkg::CS_GAP_DEF
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    qds_if.host link
);
    localparam int unsigned WORD_W = CODE_W + qds_pkg::ADDR_W;
    localparam logic [7:0] HALF_LIM = 8'(SCLK_HALF - 1);
    localparam logic [7:0] GAP_LIM = 8'(CS_GAP - 1);
    localparam logic [7:0] LAST_BIT = 8'(WORD_W - 1);

    qds_pkg::qds_state_t state;   // Frame sequencer state
    logic [WORD_W-1:0] tx;        // Word still to send
    logic [WORD_W-1:0] rx;        // Bits seen on the return line
    logic [7:0] cnt;              // Divider and gap counter
    logic [7:0] bits;             // Bits sent in this frame
    logic [2:0] pins;             // Strobe, preset and level pins
    logic sclk_q, cs_q, sdi_q;    // Link outputs
    logic wr_pend;                // Write data phase pending
    logic [7:0] wr_addr;          // Address of pending write
    logic sdo_s;                  // Synchronised return data

    // Return line crosses into the local clock
    qds_sync #(.RESET_VAL(1'b0)) u_sync_sdo (
        .clk(clk),
        .rstn(rstn),
        .din(link.sdo),
        .dout(sdo_s)
    );

    // Bus decode
    wire addr_ok = hsel & hready & (htrans == qds_pkg::HTRANS_NONSEQ);
    wire wr_tx = wr_pend & (wr_addr == qds_pkg::REG_TXWORD);
    wire wr_pins = wr_pend & (wr_addr == qds_pkg::REG_PINS);
    wire busy = (state != qds_pkg::QDS_IDLE);
    wire tick = (cnt == ((state == qds_pkg::QDS_GAP) ? GAP_LIM : HALF_LIM));
    wire [31:0] rd_mux =
        (haddr[7:0] == qds_pkg::REG_TXWORD) ? 32'(tx) :
        (haddr[7:0] == qds_pkg::REG_STATUS) ? {31'h0, busy} :
        (haddr[7:0] == qds_pkg::REG_RXWORD) ? 32'(rx) :
        (haddr[7:0] == qds_pkg::REG_PINS) ? {29'h0, pins} : 32'h0;

    // Address phase capture and read data
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h0;
            hrdata <= 32'h0;
        end else begin
            wr_pend <= addr_ok & hwrite;
            wr_addr <= haddr[7:0];
            if (addr_ok & ~hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    // Zero-wait slave, always OKAY
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hreadyout <= 1'b1;
            hresp <= qds_pkg::HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp <= qds_pkg::HRESP_OKAY;
        end
    end

    // Pin register; preset stays high unless software drives it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pins <= qds_pkg::PINS_RESET;
        end else if (wr_pins) begin
            pins <= hwdata[2:0];
        end
    end

    // Divider and gap counter
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= 8'h0;
        end else if (!busy || tick) begin
            cnt <= 8'h0;
        end else begin
            cnt <= cnt + 8'h1;
        end
    end

    // Frame sequencer: select low, whole word MSB first, select high, gap
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= qds_pkg::QDS_IDLE;
            tx <= '0;
            rx <= '0;
            bits <= 8'h0;
            sclk_q <= 1'b0;
            cs_q <= 1'b1;
            sdi_q <= 1'b0;
        end else begin
            case (state)
                qds_pkg::QDS_IDLE: begin
                    if (wr_tx) begin // Writes while busy are dropped
                        cs_q <= 1'b0;
                        sdi_q <= hwdata[WORD_W-1];
                        tx <= {hwdata[WORD_W-2:0], 1'b0};
                        bits <= 8'h0;
                        state <= qds_pkg::QDS_SETUP;
                    end
                end
                qds_pkg::QDS_SETUP: begin
                    if (tick) begin
                        sclk_q <= 1'b1;
                        rx <= {rx[WORD_W-2:0], sdo_s};
                        state <= qds_pkg::QDS_SHIFT;
                    end
                end
                qds_pkg::QDS_SHIFT: begin
                    if (tick && sclk_q) begin
                        sclk_q <= 1'b0;
                        if (bits == LAST_BIT) begin
                            cs_q <= 1'b1;
                            state <= qds_pkg::QDS_GAP;
                        end else begin
                            sdi_q <= tx[WORD_W-1];
                            tx <= {tx[WORD_W-2:0], 1'b0};
                            bits <= bits + 8'h1;
                        end
                    end else if (tick) begin
                        sclk_q <= 1'b1;
                        rx <= {rx[WORD_W-2:0], sdo_s};
                    end
                end
                qds_pkg::QDS_GAP: begin
                    if (tick) begin
                        state <= qds_pkg::QDS_IDLE;
                    end
                end
                default: begin
                    state <= qds_pkg::QDS_IDLE;
                    cs_q <= 1'b1;
                    sclk_q <= 1'b0;
                end
            endcase
        end
    end

    // Link outputs straight from flip-flops
    assign link.sclk = sclk_q;
    assign link.cs_n = cs_q;
    assign link.sdi = sdi_q;
    assign link.dac_load_strobe_n = pins[qds_pkg::PINS_STROBE_BIT];
    assign link.async_preset_n = pins[qds_pkg::PINS_PRESET_BIT];
    assign link.level_sel = pins[qds_pkg::PINS_LEVEL_BIT];
endmodule : qds_host
`default_nettype wire

//--- common/qds_pkg.sv
// Shared constants for the quad converter serial load link and its controller
package qds_pkg;
    // Code widths of the two converter variants
    localparam int unsigned CODE_W_WIDE = 16;
    localparam int unsigned CODE_W_NARROW = 14;
    // Address field width and channel count
    localparam int unsigned ADDR_W = 2;
    localparam int unsigned NUM_CH = 4;
    // Channel address codes
    localparam logic [1:0] CH_A = 2'h0;
    localparam logic [1:0] CH_B = 2'h1;
    localparam logic [1:0] CH_C = 2'h2;
    localparam logic [1:0] CH_D = 2'h3;
    // Controller register byte offsets on the AHB-Lite bus
    localparam logic [7:0] REG_TXWORD = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_RXWORD = 8'h08;
    localparam logic [7:0] REG_PINS = 8'h0c;
    // Field positions
    localparam int unsigned STATUS_BUSY_BIT = 0;
    localparam int unsigned PINS_STROBE_BIT = 0;
    localparam int unsigned PINS_PRESET_BIT = 1;
    localparam int unsigned PINS_LEVEL_BIT = 2;
    // Reset value of the pin register: strobe high, preset high, zero scale
    localparam logic [2:0] PINS_RESET = 3'h3;
    // Bus encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'h0;
    // Controller timing defaults in clk cycles
    localparam int unsigned SCLK_HALF_DEF = 2;
    localparam int unsigned CS_GAP_DEF = 8;
    // Controller states
    typedef enum logic [3:0] {
        QDS_IDLE  = 4'b0001,
        QDS_SETUP = 4'b0010,
        QDS_SHIFT = 4'b0100,
        QDS_GAP   = 4'b1000
    } qds_state_t;
endpackage : qds_pkg

//--- common/qds_if.sv
// Link between the serial load controller and the quad converter load logic
`timescale 1ns/1ps
`default_nettype none
interface qds_if;
    logic sclk;               // Serial clock, made by the controller
    logic cs_n;               // Frame select, active low
    logic sdi;                // Serial data into the converter
    logic sdo;                // Delayed serial data out of the converter
    logic dac_load_strobe_n;  // Level load strobe, active low
    logic async_preset_n;     // Preset, active low
    logic level_sel;          // Preset level: 0 zero, 1 half scale
    // Controller end
    modport host (output sclk, output cs_n, output sdi, input sdo,
                  output dac_load_strobe_n, output async_preset_n, output level_sel);
    // Converter end
    modport device (input sclk, input cs_n, input sdi, output sdo,
                    input dac_load_strobe_n, input async_preset_n, input level_sel);
endinterface : qds_if
`default_nettype wire

//--- logic/qds_sync.sv
// Two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module qds_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic din,
    output logic dout
);
    logic meta; // First stage, read only by the second

    // Two stages on the local clock
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta <= RESET_VAL;
            dout <= RESET_VAL;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule : qds_sync
`default_nettype wire

//--- logic/qds_device.sv
// Load logic of the quad current-output converter: shift register, input and converter registers
`timescale 1ns/1ps
`default_nettype none
module qds_device #(
    // Code width: 16 for the wide variant, 14 for the narrow one
    parameter int unsigned CODE_W = qds_pkg::CODE_W_WIDE
) (
    input wire logic clk,
    input wire logic rstn,
    qds_if.device link,
    output logic [qds_pkg::NUM_CH-1:0][CODE_W-1:0] input_code,
    output logic [qds_pkg::NUM_CH-1:0][CODE_W-1:0] dac_code,
    output logic load_done
);
    // Two clock domains meet here. The serial clock domain only shifts and
    // delays bits; it never sees the local clock. The local clock domain owns
    // every register that holds a code. Frame select, strobe, preset and level
    // all cross through two-stage synchronisers before any local-clock logic reads them,
    // so their effects lag by two to three local clocks.
    //
    // The shift register is the one exception: it is read straight from the
    // local domain, because the serial clock is parked whenever select is high
    // and the word cannot move while the load decision is made.

    // Word layout derived from the code width
    localparam int unsigned AW = qds_pkg::ADDR_W;
    localparam int unsigned NCH = qds_pkg::NUM_CH;
    localparam int unsigned WORD_W = CODE_W + AW;
    // Preset codes
    // Half scale is the top code bit alone, whatever the width
    localparam logic [CODE_W-1:0] ZERO_CODE = '0;
    localparam logic [CODE_W-1:0] HALF_CODE = {1'b1, {(CODE_W - 1){1'b0}}};

    // Channel decode shared by all channel slices: true when the word
    // address names the channel with the given index
    function automatic logic chan_hit(input logic [AW-1:0] addr, input logic [AW-1:0] idx);
        chan_hit = (addr == idx);
    endfunction : chan_hit

    // ---------------- Link clock domain ----------------
    logic [WORD_W-1:0] shreg; // Serial input shift register
    logic sdo_q;              // Extra stage that makes the daisy-chain delay
    // Nothing here runs while the serial clock is parked. A frame cut short
    // leaves a partial word behind; only the last word-width bits are ever
    // looked at, so a longer frame is harmless.

    // Shift one bit per serial clock rise while the frame is open
    always_ff @(posedge link.sclk or negedge rstn) begin
        if (!rstn) begin
            shreg <= '0;
        end else if (!link.cs_n) begin
            shreg <= {shreg[WORD_W-2:0], link.sdi};
        end
    end

    // Bit leaving the top appears on the output one rise later
    // The shift register holds word-width bits; this stage adds the one
    // extra pulse, so a bit reappears one word-width plus one rises later
    always_ff @(posedge link.sclk or negedge rstn) begin
        if (!rstn) begin
            sdo_q <= 1'b0;
        end else if (!link.cs_n) begin
            sdo_q <= shreg[WORD_W-1];
        end
    end

    // Daisy-chain output
    // Driven from a flop, so a device further down the chain sees clean edges
    assign link.sdo = sdo_q;

    // ---------------- Local clock domain ----------------
    // Every pin below arrives from the host's clock and is synchronised here
    logic cs_s;      // Synchronised frame select
    logic cs_d;      // Previous synchronised frame select
    logic strobe_s;  // Synchronised load strobe
    logic preset_s;  // Synchronised preset
    logic level_s;   // Synchronised preset level

    // Frame select, idle high
    qds_sync #(.RESET_VAL(1'b1)) u_sync_cs (
        .clk(clk),
        .rstn(rstn),
        .din(link.cs_n),
        .dout(cs_s)
    );

    // Load strobe, idle high
    // The strobe is level sensitive, so a plain level synchroniser suffices
    qds_sync #(.RESET_VAL(1'b1)) u_sync_strobe (
        .clk(clk),
        .rstn(rstn),
        .din(link.dac_load_strobe_n),
        .dout(strobe_s)
    );

    // Preset, idle high
    // Asynchronous at the pin; synchronising it costs two clocks of latency
    // but keeps every code register on the one local clock
    qds_sync #(.RESET_VAL(1'b1)) u_sync_preset (
        .clk(clk),
        .rstn(rstn),
        .din(link.async_preset_n),
        .dout(preset_s)
    );

    // Preset level select
    qds_sync #(.RESET_VAL(1'b0)) u_sync_level (
        .clk(clk),
        .rstn(rstn),
        .din(link.level_sel),
        .dout(level_s)
    );

    // Edge history of the synchronised select
    // Reset value matches the idle level of the pin, so no false rise
    // follows the release of reset
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cs_d <= 1'b1;
        end else begin
            cs_d <= cs_s;
        end
    end

    // Decoding and selection
    // The rise of the synchronised select marks the end of a frame; from then
    // on the shift register is frozen until the next frame opens, which is at
    // least the host's gap later
    wire cs_rise = cs_s & ~cs_d;        // Frame closed; needs no serial clock
    wire preset_on = ~preset_s;         // Preset held low
    wire follow = ~strobe_s;            // Converter registers transparent
    // Shift register is stable while select is high, so it is read directly here
    wire [AW-1:0] word_addr = shreg[WORD_W-1 -: AW];
    wire channel_addr_hi = word_addr[1];                  // Top word bit
    wire channel_addr_lo = word_addr[0];                  // Next word bit
    wire [CODE_W-1:0] word_code = shreg[CODE_W-1:0];
    wire code_top_bit = word_code[CODE_W-1];              // Code sent first after address
    wire [CODE_W-1:0] preset_code = level_s ? HALF_CODE : ZERO_CODE;
    wire [NCH-1:0] load_hit;                              // Per-channel load pulse

    // Per-channel input and converter registers
    // Preset is checked first in each slice, so it wins even against a load
    // or a strobe transfer that falls in the same cycle
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_ch
            localparam logic [AW-1:0] IDX = AW'(g);

            // Address decode for this channel
            assign load_hit[g] = cs_rise & chan_hit({channel_addr_hi, channel_addr_lo}, IDX);

            // Input register: preset first, then frame load
            // Latched at every other time
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    input_code[g] <= ZERO_CODE;
                end else if (preset_on) begin
                    input_code[g] <= preset_code;
                end else if (load_hit[g]) begin
                    input_code[g] <= word_code;
                end
            end

            // Converter register: preset first, then follows while strobe low
            // Holds while the strobe is high, so all four change together
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    dac_code[g] <= ZERO_CODE;
                end else if (preset_on) begin
                    dac_code[g] <= preset_code;
                end else if (follow) begin
                    dac_code[g] <= input_code[g];
                end
            end
        end
    endgenerate

    // Limitation: the load decision needs select high for at least three
    // local clocks, and the local clock must run; the shift register itself
    // keeps working with the local clock stopped.

    // One-cycle pulse for each accepted frame load
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            load_done <= 1'b0;
        end else begin
            load_done <= cs_rise & ~preset_on & code_top_bit | cs_rise & ~preset_on & ~code_top_bit;
        end
    end
endmodule : qds_device
`default_nettype wire

//--- verification/qds_link_properties.sv
// Checker for the serial link between the load controller and the converter
`timescale 1ns/1ps
`default_nettype none
module qds_link_properties #(
    parameter int unsigned CODE_W = qds_pkg::CODE_W_WIDE
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    input wire logic sdo
);
    localparam int WORD_W = CODE_W + 2; // Address plus code bits
    localparam int DLY = WORD_W + 1; // Serial clock rises from input to output
    logic sclk_q; // Serial clock one clk earlier
    logic [7:0] frame_rises; // Rises inside the current frame
    logic [7:0] link_rises; // Rises since reset, saturating
    wire rise_seen = sclk & ~sclk_q; // Serial clock rise seen in clk domain
    // Count rises of the current frame
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sclk_q <= 1'b0;
            frame_rises <= 8'h0;
        end else begin
            sclk_q <= sclk;
            frame_rises <= cs_n ? 8'h0 : frame_rises + {7'h0, rise_seen};
        end
    end
    // Count rises until the delay line is full
    always_ff @(posedge sclk or negedge rstn) begin
        if (!rstn) begin
            link_rises <= 8'h0;
        end else if (link_rises < 8'(DLY)) begin
            link_rises <= link_rises + 8'h1;
        end
    end
    // Select stays high between frames
    sequence s_gap;
        cs_n [*8];
    endsequence
    // Select stays low once a frame opens
    sequence s_open;
        !cs_n [*8];
    endsequence
    // One high phase of two clk, then low
    sequence s_pulse;
        sclk [*2] ##1 !sclk;
    endsequence
    a_sclk_idle_low: assert property (@(posedge clk) disable iff (!rstn)
        cs_n |-> !sclk) else $error("serial clock moved outside a frame");
    a_sdi_setup_hold: assert property (@(posedge clk) disable iff (!rstn)
        $changed(sdi) |-> !sclk) else $error("data changed while serial clock high");
    a_sclk_pulse_shape: assert property (@(posedge clk) disable iff (!rstn)
        $rose(sclk) |-> s_pulse) else $error("serial clock pulse has wrong width");
    a_frame_bit_count: assert property (@(posedge clk) disable iff (!rstn)
        $rose(cs_n) |-> frame_rises == 8'(WORD_W)) else $error("frame has wrong bit count");
    a_cs_gap_hold: assert property (@(posedge clk) disable iff (!rstn)
        $rose(cs_n) |-> s_gap) else $error("select gap too short");
    a_cs_frame_low: assert property (@(posedge clk) disable iff (!rstn)
        $fell(cs_n) |-> s_open) else $error("select rose too early in a frame");
    a_sdo_quiet_idle: assert property (@(posedge clk) disable iff (!rstn)
        !$rose(sclk) |-> $stable(sdo)) else $error("serial output moved without a rise");
    a_sdo_delay_line: assert property (@(posedge sclk) disable iff (!rstn)
        link_rises >= 8'(DLY) |-> sdo == $past(sdi, DLY)) else $error("serial output delay wrong");
endmodule : qds_link_properties
`default_nettype wire

//--- verification/quad_dac_serial_load_test.sv
// Bench: serial load controller driving the quad converter load logic
`timescale 1ns/1ps
`default_nettype none
module quad_dac_serial_load_test;
    localparam int unsigned CW = qds_pkg::CODE_W_WIDE; // Wide variant
    logic clk = 1'b0; // Controller clock
    logic clk_dev = 1'b0; // Converter local clock
    logic rstn = 1'b0; // Shared reset
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [qds_pkg::NUM_CH-1:0][CW-1:0] input_code; // Input registers
    logic [qds_pkg::NUM_CH-1:0][CW-1:0] dac_code; // Converter registers
    logic load_done;
    logic [CW-1:0] exp_in [4] = '{default: '0}; // Expected input registers
    logic [CW-1:0] exp_dac [4] = '{default: '0}; // Expected converter registers
    int num_errors = 0;
    int checks = 0;
    int loads = 0; // Accepted frame loads
    qds_if link();
    // Clocks, unrelated in phase
    always #20 clk = ~clk;
    always #17.5 clk_dev = ~clk_dev;
    // Count load pulses in the converter domain
    always @(posedge clk_dev) if (load_done === 1'b1) loads++;
    qds_host #(.CODE_W(CW)) u_qds_host (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link(link.host));
    qds_device #(.CODE_W(CW)) u_qds_device (.clk(clk_dev), .rstn(rstn), .link(link.device),
        .input_code(input_code), .dac_code(dac_code), .load_done(load_done));
    qds_link_properties #(.CODE_W(CW)) u_qds_link_properties (.clk(clk), .rstn(rstn),
        .sclk(link.sclk), .cs_n(link.cs_n), .sdi(link.sdi), .sdo(link.sdo));
    // Report the counts and end the run
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish
    task automatic fail(input string msg);
        $display("ERROR at %0t: %s", $time, msg);
        num_errors++;
    endtask : fail
    // Compare a bus word
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) fail($sformatf("%s got %h expected %h", what, got, exp));
    endtask : chk_word
    // Compare a register code
    task automatic chk_code(input logic [CW-1:0] got, input logic [CW-1:0] exp, input string what);
        checks++;
        if (got !== exp) fail($sformatf("%s got %h expected %h", what, got, exp));
    endtask : chk_code
    // Wait for ready at a rising edge, bounded
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge clk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                fail("bus wait timed out");
                tally_and_finish();
            end
            @(posedge clk);
        end
    endtask : wait_ready
    // One single word transfer
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= qds_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        wait_ready();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask : bus
    // Poll status until the frame and gap are over
    task automatic wait_idle();
        logic [31:0] s;
        int n;
        n = 0;
        s = 32'h1;
        while (s[qds_pkg::STATUS_BUSY_BIT] !== 1'b0) begin
            if (++n > 200) begin
                fail("busy never dropped");
                tally_and_finish();
            end
            bus(1'b0, qds_pkg::REG_STATUS, 32'h0, s);
        end
        repeat (2) @(posedge clk);
    endtask : wait_idle
    // Send one word to a channel
    task automatic send(input logic [1:0] ch, input logic [CW-1:0] code);
        logic [31:0] d;
        bus(1'b1, qds_pkg::REG_TXWORD, 32'({ch, code}), d);
        wait_idle();
    endtask : send
    // Write the pin register and let the synchronisers settle
    task automatic set_pins(input logic [2:0] p);
        logic [31:0] d;
        bus(1'b1, qds_pkg::REG_PINS, {29'h0, p}, d);
        repeat (8) @(posedge clk);
    endtask : set_pins
    // Compare all eight registers
    task automatic check_all();
        for (int i = 0; i < 4; i++) begin
            chk_code(input_code[i], exp_in[i], $sformatf("input %0d", i));
            chk_code(dac_code[i], exp_dac[i], $sformatf("dac %0d", i));
        end
    endtask : check_all
    // Reset state, pin register default, unmapped write ignored
    task automatic t_reset();
        logic [31:0] r;
        check_all();
        bus(1'b0, qds_pkg::REG_PINS, 32'h0, r);
        chk_word(r, 32'(qds_pkg::PINS_RESET), "pins");
        bus(1'b1, 8'h10, 32'h3_ffff, r);
        bus(1'b0, 8'h10, 32'h0, r);
        chk_word(r, 32'h0, "unmapped");
        repeat (8) @(posedge clk);
        check_all();
    endtask : t_reset
    // Every address, boundary codes, strobe held high
    task automatic t_channels();
        logic [CW-1:0] codes [4] = '{16'h8001, 16'h4002, 16'h0001, 16'hffff};
        logic [31:0] r;
        for (int ch = 0; ch < 4; ch++) begin
            send(ch[1:0], codes[ch]);
            exp_in[ch] = codes[ch];
        end
        check_all();
        chk_word(32'(loads), 32'h4, "load count");
        // Return line lags by word-width plus one rises: the fourth frame sees
        // the last bit of the second word, then the third word less its last bit
        bus(1'b0, qds_pkg::REG_RXWORD, 32'h0, r);
        chk_word(r, 32'({codes[1][0], qds_pkg::CH_C, codes[2][CW-1:1]}), "return word");
    endtask : t_channels
    // Strobe low makes converter registers follow, high holds them
    task automatic t_strobe();
        set_pins(3'h2);
        for (int i = 0; i < 4; i++) exp_dac[i] = exp_in[i];
        check_all();
        send(2'h1, 16'h5a5a);
        exp_in[1] = 16'h5a5a;
        exp_dac[1] = 16'h5a5a;
        check_all();
        set_pins(3'h3);
        send(2'h2, 16'h1234);
        exp_in[2] = 16'h1234;
        check_all();
    endtask : t_strobe
    // Preset to half and zero scale outranks strobe and frame loads
    task automatic t_preset();
        int loads_before;
        set_pins(3'h4);
        for (int i = 0; i < 4; i++) exp_in[i] = 16'h8000;
        for (int i = 0; i < 4; i++) exp_dac[i] = 16'h8000;
        check_all();
        loads_before = loads;
        send(2'h3, 16'h0f0f);
        check_all();
        chk_word(32'(loads), 32'(loads_before), "load during preset");
        set_pins(3'h1);
        for (int i = 0; i < 4; i++) exp_in[i] = 16'h0;
        for (int i = 0; i < 4; i++) exp_dac[i] = 16'h0;
        check_all();
        set_pins(3'h3);
        send(2'h0, 16'h7ffe);
        exp_in[0] = 16'h7ffe;
        check_all();
    endtask : t_preset
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_channels();
        t_strobe();
        t_preset();
        tally_and_finish();
    end
endmodule : quad_dac_serial_load_test
`default_nettype wire
